/* core/dic_device.sv */
// Device end: sixteen channel input sampler, filters and totalize counters
`timescale 1ns/1ns
`default_nettype none
module dic_device
  import dic_pkg::*;
#(
  parameter int FAST_CYC = DEB_FAST_CYC,
  parameter int SLOW_CYC = DEB_SLOW_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  dic_if.dev                     link,
  input  wire logic [NUM_CH-1:0] field_in,
  input  wire logic              debounce_slow,
  input  wire logic [15:0]       term_id_pins
);
  // Filter counters are 27 bits wide
  if (FAST_CYC < 1 || SLOW_CYC < 1 || FAST_CYC >= 2**27 || SLOW_CYC >= 2**27) begin : g_bad_cyc
    $error("dic_device: bad debounce counts");
  end

  // ****************************************************************
  // Input synchronisers and debounce filters
  // ****************************************************************
  logic [NUM_CH-1:0] s1_r, s2_r, filt_r, prev_r;
  logic [NUM_CH-1:0] s1_nxt, s2_nxt, filt_nxt, prev_nxt;
  logic [26:0]       deb_r   [NUM_CH];
  logic [26:0]       deb_nxt [NUM_CH];
  logic [26:0]       deb_lim;
  logic [NUM_CH-1:0] rise, fall;

  always_comb begin
    deb_lim = debounce_slow ? 27'(SLOW_CYC - 1) : 27'(FAST_CYC - 1);
    s1_nxt   = field_in;
    s2_nxt   = s1_r;
    prev_nxt = filt_r;
    filt_nxt = filt_r;
    for (int i = 0; i < NUM_CH; i++) begin
      deb_nxt[i] = '0;
      if (s2_r[i] != filt_r[i]) begin
        if (deb_r[i] >= deb_lim) begin
          filt_nxt[i] = s2_r[i];
        end else begin
          deb_nxt[i] = deb_r[i] + 27'h0000001;
        end
      end
    end
    rise = filt_r & ~prev_r;
    fall = ~filt_r & prev_r;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r   <= '0;
      s2_r   <= '0;
      filt_r <= '0;
      prev_r <= '0;
      for (int i = 0; i < NUM_CH; i++) deb_r[i] <= '0;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      filt_r <= filt_nxt;
      prev_r <= prev_nxt;
      for (int i = 0; i < NUM_CH; i++) deb_r[i] <= deb_nxt[i];
    end
  end

  // ****************************************************************
  // Channel configuration and counters
  // ****************************************************************
  logic [CH_W-1:0]   sel_r, sel_nxt;
  logic [NUM_CH-1:0] armed_r, armed_nxt;
  logic [NUM_CH-1:0] fall_r, fall_mode_nxt;
  logic [NUM_CH-1:0] modon_r, modon_nxt;
  logic [15:0]       modn_r   [NUM_CH];
  logic [15:0]       modn_nxt [NUM_CH];
  logic [CNT_W-1:0]  cnt_r    [NUM_CH];
  logic [CNT_W-1:0]  cnt_nxt  [NUM_CH];
  logic              irq_edge_r, irq_edge_nxt;
  logic              irq_en_r, irq_en_nxt;
  logic              irq_r, irq_nxt;
  logic              rsp_v_r, rsp_v_nxt;
  logic [31:0]       rsp_d_r, rsp_d_nxt;
  logic              cmd;

  always_comb begin
    cmd           = link.cmd_valid;
    sel_nxt       = sel_r;
    armed_nxt     = armed_r;
    fall_mode_nxt = fall_r;
    modon_nxt     = modon_r;
    irq_edge_nxt  = irq_edge_r;
    irq_en_nxt    = irq_en_r;
    rsp_v_nxt     = 1'b0;
    rsp_d_nxt     = rsp_d_r;
    for (int i = 0; i < NUM_CH; i++) begin
      modn_nxt[i] = modn_r[i];
      cnt_nxt[i]  = cnt_r[i];
      // Each channel only sees its own edges; selection never clears
      if (armed_r[i] && (fall_r[i] ? fall[i] : rise[i])) begin
        if (modon_r[i] && cnt_r[i] >= {16'h0000, modn_r[i]} - 32'h1) begin
          cnt_nxt[i] = '0;
        end else begin
          cnt_nxt[i] = cnt_r[i] + 32'h1;
        end
      end
    end
    if (cmd) begin
      case (link.cmd_code)
        DIC_CMD_RESET: begin
          sel_nxt    = '0;
          armed_nxt  = '0;
          fall_mode_nxt = '0;
          modon_nxt  = '0;
          irq_en_nxt = 1'b0;
          irq_edge_nxt = 1'b0;
          for (int i = 0; i < NUM_CH; i++) begin
            cnt_nxt[i]  = RST_COUNT;
            modn_nxt[i] = '0;
          end
        end
        DIC_CMD_USE: begin
          // Whole argument compared so an oversized channel is ignored
          if (link.cmd_arg <= {27'h0000000, IRQ_CH}) sel_nxt = link.cmd_arg[CH_W-1:0];
        end
        DIC_CMD_EDGE: begin
          if (sel_r == IRQ_CH) begin
            irq_edge_nxt = link.cmd_arg[0];
          end else begin
            fall_mode_nxt[sel_r[3:0]] = link.cmd_arg[0];
            armed_nxt[sel_r[3:0]]     = 1'b1;
          end
        end
        DIC_CMD_MODULO: begin
          if (sel_r != IRQ_CH) begin
            modon_nxt[sel_r[3:0]] = link.cmd_arg[15:0] >= MOD_MIN;
            modn_nxt[sel_r[3:0]]  = link.cmd_arg[15:0];
            cnt_nxt[sel_r[3:0]]   = '0;
          end
        end
        DIC_CMD_INTERRUPT_INDICATOR_EN:  irq_en_nxt = 1'b1;
        DIC_CMD_INTERRUPT_INDICATOR_DIS: irq_en_nxt = 1'b0;
        DIC_CMD_PAT_READ: begin
          rsp_v_nxt = 1'b1;
          rsp_d_nxt = {{16{filt_r[15]}}, filt_r};
        end
        DIC_CMD_CH_READ: begin
          rsp_v_nxt = 1'b1;
          rsp_d_nxt = cnt_r[link.cmd_arg[3:0]];
        end
        default: rsp_v_nxt = 1'b0;
      endcase
    end
    // Pending until pattern read, disable or reset; set wins over a same-cycle read or disable
    irq_nxt = irq_r;
    // A set that won over a disable must not outlive the disabled cycle
    if (!irq_en_r || !irq_en_nxt) irq_nxt = 1'b0;
    if (cmd && link.cmd_code == DIC_CMD_PAT_READ) irq_nxt = 1'b0;
    if (irq_en_r && |((irq_edge_r ? fall : rise) & 16'h5555)) irq_nxt = 1'b1;
    if (cmd && link.cmd_code == DIC_CMD_RESET) irq_nxt = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r      <= '0;
      armed_r    <= '0;
      fall_r     <= '0;
      modon_r    <= '0;
      irq_edge_r <= 1'b0;
      irq_en_r   <= 1'b0;
      irq_r      <= 1'b0;
      rsp_v_r    <= 1'b0;
      rsp_d_r    <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        modn_r[i] <= '0;
        cnt_r[i]  <= RST_COUNT;
      end
    end else begin
      sel_r      <= sel_nxt;
      armed_r    <= armed_nxt;
      fall_r     <= fall_mode_nxt;
      modon_r    <= modon_nxt;
      irq_edge_r <= irq_edge_nxt;
      irq_en_r   <= irq_en_nxt;
      irq_r      <= irq_nxt;
      rsp_v_r    <= rsp_v_nxt;
      rsp_d_r    <= rsp_d_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        modn_r[i] <= modn_nxt[i];
        cnt_r[i]  <= cnt_nxt[i];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic [15:0] id_r, id_nxt;

  always_comb begin
    id_nxt = term_id_pins;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      id_r <= '0;
    end else begin
      id_r <= id_nxt;
    end
  end

  assign link.rsp_valid = rsp_v_r;
  assign link.rsp_data  = rsp_d_r;
  assign link.irq       = irq_r;
  assign link.term_id   = id_r;
endmodule : dic_device
`default_nettype wire

/* core/dic_pkg.sv */
// Package: constants and types shared by the digital input counter ends
// Notes on behaviour
// - Pattern read returns all sixteen levels
// - Channel n sits in word bit n
// - All inputs high reads minus one
// - Host resets block; channels go known
// - Rising edges count once each when selected
// - Other channels never bump this counter
// - Counters keep value across reselection
// - Selectable debounce filter with 10 Hz setting
// - Host arms interrupt: select 16, rising, enable
// - Armed interrupt fires on even rising edges
// - Identity lines; host refuses on mismatch
// - Falling edge mode counts falling transitions
// - Counters are 32-bit signed
// - Modulo mode wraps at N, 2..65535
package dic_pkg;
  localparam int          NUM_CH       = 16;
  localparam int          CNT_W        = 32;
  localparam int          CH_W         = 5;
  localparam logic [4:0]  IRQ_CH       = 5'h10;
  localparam int          CLK_HZ       = 125000000;
  localparam int          DEB_FAST_HZ  = 1000;
  localparam int          DEB_SLOW_HZ  = 10;
  // Filter settle time is half the setting's period
  localparam int          DEB_FAST_CYC = CLK_HZ / (2 * DEB_FAST_HZ);
  localparam int          DEB_SLOW_CYC = CLK_HZ / (2 * DEB_SLOW_HZ);
  localparam logic [15:0] MOD_MIN      = 16'h0002;
  localparam logic [15:0] ID_OK        = 16'h0A5C; // Arbitrary identity value
  localparam logic [15:0] RST_PATTERN  = 16'h0000;
  localparam logic [31:0] RST_COUNT    = 32'h0000_0000;

  typedef enum logic [2:0] {
    DIC_CMD_RESET,
    DIC_CMD_USE,
    DIC_CMD_EDGE,
    DIC_CMD_MODULO,
    DIC_CMD_INTERRUPT_INDICATOR_EN,
    DIC_CMD_INTERRUPT_INDICATOR_DIS,
    DIC_CMD_PAT_READ,
    DIC_CMD_CH_READ
  } dic_cmd_t;
endpackage : dic_pkg

/* core/dic_if.sv */
// Interface: command link between host controller and input block
`timescale 1ns/1ns
`default_nettype none
interface dic_if;
  import dic_pkg::*;
  logic        cmd_valid;
  dic_cmd_t    cmd_code;
  logic [31:0] cmd_arg;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        irq;
  logic [15:0] term_id;

  modport dev  (input cmd_valid, cmd_code, cmd_arg,
                output rsp_valid, rsp_data, irq, term_id);
  modport host (output cmd_valid, cmd_code, cmd_arg,
                input rsp_valid, rsp_data, irq, term_id);
endinterface : dic_if
`default_nettype wire

/* core/dic_host.sv */
// Host end: forwards user commands, checks terminal identity
`timescale 1ns/1ns
`default_nettype none
module dic_host
  import dic_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  dic_if.host              link,
  input  wire logic        usr_valid,
  input  wire dic_cmd_t    usr_code,
  input  wire logic [31:0] usr_arg,
  output logic             usr_busy,
  output logic             usr_refused,
  output logic             usr_done,
  output logic [31:0]      usr_data,
  output logic             interrupt_indicator
);
  typedef enum logic [1:0] {DH_IDLE, DH_WAIT} dic_hst_t;
  dic_hst_t    st_r, st_nxt;
  logic        cv_r, cv_nxt, busy_nxt, ref_r, ref_nxt, done_r, done_nxt, ind_r, ind_nxt;
  dic_cmd_t    cc_r, cc_nxt;
  logic [31:0] ca_r, ca_nxt, dat_r, dat_nxt;
  logic        needs_id, reads;

  always_comb begin
    st_nxt = st_r;
    cv_nxt = 1'b0;
    cc_nxt = cc_r;
    ca_nxt = ca_r;
    ref_nxt = 1'b0;
    done_nxt = 1'b0;
    dat_nxt = dat_r;
    ind_nxt = link.irq;
    // Counting and interrupt setup need the right terminal fitted
    needs_id = usr_code inside {DIC_CMD_EDGE, DIC_CMD_MODULO, DIC_CMD_INTERRUPT_INDICATOR_EN};
    reads = usr_code inside {DIC_CMD_PAT_READ, DIC_CMD_CH_READ};
    case (st_r)
      DH_IDLE: begin
        if (usr_valid) begin
          if (needs_id && link.term_id != ID_OK) begin
            ref_nxt = 1'b1;
          end else begin
            cv_nxt = 1'b1;
            cc_nxt = usr_code;
            ca_nxt = usr_arg;
            if (reads) st_nxt = DH_WAIT;
            else done_nxt = 1'b1;
          end
        end
      end
      DH_WAIT: begin
        if (link.rsp_valid) begin
          dat_nxt  = link.rsp_data;
          done_nxt = 1'b1;
          st_nxt   = DH_IDLE;
        end
      end
      default: st_nxt = DH_IDLE;
    endcase
    busy_nxt = (st_nxt != DH_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r     <= DH_IDLE;
      cv_r     <= 1'b0;
      cc_r     <= DIC_CMD_RESET;
      ca_r     <= '0;
      usr_busy <= 1'b0;
      ref_r    <= 1'b0;
      done_r   <= 1'b0;
      dat_r    <= '0;
      ind_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cv_r     <= cv_nxt;
      cc_r     <= cc_nxt;
      ca_r     <= ca_nxt;
      usr_busy <= busy_nxt;
      ref_r    <= ref_nxt;
      done_r   <= done_nxt;
      dat_r    <= dat_nxt;
      ind_r    <= ind_nxt;
    end
  end

  assign link.cmd_valid      = cv_r;
  assign link.cmd_code       = cc_r;
  assign link.cmd_arg        = ca_r;
  assign usr_refused         = ref_r;
  assign usr_done            = done_r;
  assign usr_data            = dat_r;
  assign interrupt_indicator = ind_r;
endmodule : dic_host
`default_nettype wire

/* verif/dic_asserts.sv */
// Checker: link protocol and interrupt properties between host and device
`timescale 1ns/1ns
`default_nettype none
module dic_asserts
  import dic_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        cmd_valid,
  input wire dic_cmd_t    cmd_code,
  input wire logic [31:0] cmd_arg,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic        irq,
  input wire logic [15:0] term_id
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rd_cmd;
  logic svc;
  logic arm_r;
  logic arm_nxt;
  assign rd_cmd = cmd_valid && cmd_code inside {DIC_CMD_PAT_READ, DIC_CMD_CH_READ};
  assign svc = cmd_valid && cmd_code inside {DIC_CMD_PAT_READ, DIC_CMD_INTERRUPT_INDICATOR_DIS, DIC_CMD_RESET};
  // ************************
  // Interrupt arm tracker
  // ************************
  always_comb begin
    arm_nxt = arm_r;
    if (cmd_valid && cmd_code == DIC_CMD_INTERRUPT_INDICATOR_EN) arm_nxt = 1'b1;
    if (cmd_valid && cmd_code inside {DIC_CMD_INTERRUPT_INDICATOR_DIS, DIC_CMD_RESET}) arm_nxt = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) arm_r <= 1'b0;
    else arm_r <= arm_nxt;
  end
  // ************************
  // Properties
  // ************************
  a_rsp_after_read: assert property (rd_cmd |=> rsp_valid)
    else $error("read got no response");
  a_rsp_only_read: assert property (rsp_valid |-> $past(rd_cmd))
    else $error("response without read");
  a_rsp_data_hold: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("response data moved");
  a_pat_sign_ext: assert property (rsp_valid && $past(cmd_code) == DIC_CMD_PAT_READ
    |-> rsp_data[31:16] == {16{rsp_data[15]}}) else $error("pattern not sign extended");
  a_irq_stays_up: assert property (irq && arm_r && !svc |=> irq)
    else $error("interrupt dropped unserviced");
  a_irq_cleared: assert property (cmd_valid && cmd_code == DIC_CMD_INTERRUPT_INDICATOR_DIS |-> ##2 !irq)
    else $error("interrupt not cleared");
  a_irq_needs_arm: assert property (irq |-> arm_r || $past(arm_r))
    else $error("interrupt while not armed");
  a_id_gates_cmd: assert property (cmd_valid && cmd_code inside
    {DIC_CMD_EDGE, DIC_CMD_MODULO, DIC_CMD_INTERRUPT_INDICATOR_EN} |-> term_id == ID_OK)
    else $error("command sent with wrong identity");
  c_read: cover property (rd_cmd ##1 rsp_valid);
  c_irq: cover property ($rose(irq));
  c_modulo: cover property (cmd_valid && cmd_code == DIC_CMD_MODULO);
  c_irq_sel: cover property (cmd_valid && cmd_code == DIC_CMD_USE && cmd_arg[4:0] == IRQ_CH);
endmodule // dic_asserts
`default_nettype wire

/* verif/tb_sixteen_channel_digital_input_counter.sv */
// Testbench: host and device joined, driven from the user and field sides
`timescale 1ns/1ns
`default_nettype none
module tb_sixteen_channel_digital_input_counter;
  import dic_pkg::*;
  logic        ref_clk;
  logic        rst_b;
  logic        usr_valid;
  dic_cmd_t    usr_code;
  logic [31:0] usr_arg;
  logic        usr_busy;
  logic        usr_refused;
  logic        usr_done;
  logic [31:0] usr_data;
  logic        interrupt_indicator;
  logic [15:0] field_in;
  logic        debounce_slow;
  logic [15:0] term_id_pins;
  logic [31:0] rd;
  logic        refd;
  int          bad_count;
  int          comparisons;
  dic_if lnk();
  dic_device #(.FAST_CYC(4), .SLOW_CYC(8)) i_dic_device (.ref_clk, .rst_b, .link(lnk),
    .field_in, .debounce_slow, .term_id_pins);
  dic_host i_dic_host (.ref_clk, .rst_b, .link(lnk), .usr_valid, .usr_code, .usr_arg,
    .usr_busy, .usr_refused, .usr_done, .usr_data, .interrupt_indicator);
  dic_asserts i_dic_asserts (.ref_clk, .rst_b, .cmd_valid(lnk.cmd_valid),
    .cmd_code(lnk.cmd_code), .cmd_arg(lnk.cmd_arg), .rsp_valid(lnk.rsp_valid),
    .rsp_data(lnk.rsp_data), .irq(lnk.irq), .term_id(lnk.term_id));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ************************
  // Shared tasks
  // ************************
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Samples on the falling edge so single-cycle pulses are never missed
  task automatic cmd(input dic_cmd_t c, input logic [31:0] a);
    int i;
    logic is_rd;
    is_rd = c inside {DIC_CMD_PAT_READ, DIC_CMD_CH_READ};
    usr_valid <= 1'b1;
    usr_code  <= c;
    usr_arg   <= a;
    cyc(1);
    usr_valid <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if (i == 0) begin
        chk("busy", {31'h0000_0000, is_rd}, {31'h0000_0000, usr_busy});
      end
      if (usr_done === 1'b1 || usr_refused === 1'b1) break;
    end
    rd   = usr_data;
    refd = usr_refused;
    if (i == 20) begin
      chk("done", 32'h0000_0001, 32'h0000_0000);
      results();
    end
    cyc(1);
  endtask
  // Each level is held well past sync and slow filter settle
  task automatic pulse(input logic [15:0] m, input int n);
    repeat (n) begin
      field_in <= m;
      cyc(20);
      field_in <= 16'h0000;
      cyc(20);
    end
  endtask
  // ************************
  // Scenarios
  // ************************
  task automatic t_pattern;
    logic [15:0] pat [4] = '{16'h5555, 16'h0000, 16'hAAAA, 16'hFFFF};
    cmd(DIC_CMD_RESET, 32'h0000_0000);
    foreach (pat[i]) begin
      field_in <= pat[i];
      cyc(20);
      cmd(DIC_CMD_PAT_READ, 32'h0000_0000);
      chk("pattern", {{16{pat[i][15]}}, pat[i]}, rd);
    end
    field_in <= 16'h0000;
    cyc(20);
  endtask
  task automatic t_count;
    debounce_slow <= 1'b1;
    // Channel 1 armed first, so stray even edges would show on it
    cmd(DIC_CMD_USE, 32'h0000_0001);
    cmd(DIC_CMD_EDGE, 32'h0000_0000);
    cmd(DIC_CMD_USE, 32'h0000_0000);
    cmd(DIC_CMD_EDGE, 32'h0000_0000);
    pulse(16'h5555, 3);
    cmd(DIC_CMD_CH_READ, 32'h0000_0000);
    chk("ch0 count", 32'h0000_0003, rd);
    cmd(DIC_CMD_CH_READ, 32'h0000_0001);
    chk("ch1 idle", 32'h0000_0000, rd);
    cmd(DIC_CMD_USE, 32'h0000_0001);
    cmd(DIC_CMD_EDGE, 32'h0000_0000);
    pulse(16'hAAAA, 3);
    field_in <= 16'hAAAA;
    cyc(5);
    field_in <= 16'h0000;
    cyc(20);
    cmd(DIC_CMD_CH_READ, 32'h0000_0001);
    chk("ch1 count", 32'h0000_0003, rd);
    cmd(DIC_CMD_CH_READ, 32'h0000_0000);
    chk("ch0 kept", 32'h0000_0003, rd);
  endtask
  task automatic t_fall_mod;
    cmd(DIC_CMD_RESET, 32'h0000_0000);
    cmd(DIC_CMD_CH_READ, 32'h0000_0000);
    chk("ch0 reset", RST_COUNT, rd);
    cmd(DIC_CMD_USE, 32'h0000_0002);
    cmd(DIC_CMD_EDGE, 32'h0000_0001);
    pulse(16'h5555, 2);
    cmd(DIC_CMD_CH_READ, 32'h0000_0002);
    chk("ch2 falling", 32'h0000_0002, rd);
    cmd(DIC_CMD_USE, 32'h0000_0004);
    cmd(DIC_CMD_EDGE, 32'h0000_0000);
    cmd(DIC_CMD_MODULO, {16'h0000, MOD_MIN});
    pulse(16'h5555, 3);
    cmd(DIC_CMD_CH_READ, 32'h0000_0004);
    chk("ch4 modulo", 32'h0000_0001, rd);
  endtask
  task automatic t_irq;
    cmd(DIC_CMD_USE, {27'h0, IRQ_CH});
    cmd(DIC_CMD_EDGE, 32'h0000_0000);
    cmd(DIC_CMD_INTERRUPT_INDICATOR_EN, 32'h0000_0000);
    pulse(16'hAAAA, 1);
    chk("irq odd", 32'h0000_0000, {31'h0, interrupt_indicator});
    pulse(16'h5555, 1);
    cyc(30);
    chk("irq held", 32'h0000_0001, {31'h0, interrupt_indicator});
    cmd(DIC_CMD_PAT_READ, 32'h0000_0000);
    cyc(3);
    chk("irq served", 32'h0000_0000, {31'h0, interrupt_indicator});
    cmd(DIC_CMD_INTERRUPT_INDICATOR_DIS, 32'h0000_0000);
    // Falling edge interrupt setting
    cmd(DIC_CMD_USE, {27'h0000000, IRQ_CH});
    cmd(DIC_CMD_EDGE, 32'h0000_0001);
    cmd(DIC_CMD_INTERRUPT_INDICATOR_EN, 32'h0000_0000);
    field_in <= 16'h5555;
    cyc(20);
    chk("irq on rise", 32'h0000_0000, {31'h0, interrupt_indicator});
    field_in <= 16'h0000;
    cyc(20);
    chk("irq on fall", 32'h0000_0001, {31'h0, interrupt_indicator});
    cmd(DIC_CMD_INTERRUPT_INDICATOR_DIS, 32'h0000_0000);
    cyc(3);
    chk("irq disabled", 32'h0000_0000, {31'h0, interrupt_indicator});
  endtask
  task automatic t_refuse;
    term_id_pins <= 16'h0000;
    cyc(3);
    cmd(DIC_CMD_EDGE, 32'h0000_0000);
    chk("refused", 32'h0000_0001, {31'h0, refd});
    term_id_pins <= ID_OK;
    cyc(3);
  endtask
  initial begin
    rst_b         = 1'b0;
    usr_valid     = 1'b0;
    usr_code      = DIC_CMD_RESET;
    usr_arg       = 32'h0000_0000;
    field_in      = 16'h0000;
    debounce_slow = 1'b0;
    term_id_pins  = ID_OK;
    bad_count     = 0;
    comparisons   = 0;
    cyc(5);
    rst_b <= 1'b1;
    cyc(1);
    t_pattern();
    t_count();
    t_fall_mod();
    t_irq();
    t_refuse();
    results();
  end
endmodule // tb_sixteen_channel_digital_input_counter
`default_nettype wire
